// File: design/indexed_port_watchdog_timer.v
// Watchdog timer reached through an index/data I/O port pair.
// Assumes the host issues single-cycle I/O read/write strobes synchronous to clock.
`timescale 1ns/100ps
`include "wdt_defines.vh"
// Function
// - Timeout count 1 to 255 units.
// - No restart before expiry gives timeout.
// - Static jumper selects reset or interrupt.
// - Interrupt active low until restart.
// - Index port 2E, data port 2F.
// - Double unlock key opens configuration.
// - Device select 08 at 07 picks watchdog.
// - Enable register at 30, off after reset.
// - Bit 3 at F5 selects minutes.
// - Count register F6, zero stops timer.
// - Writing count restarts from new value.
// - Bit 6 at F7 lets keyboard restart.
// - Bit 5 forces timeout, self-clearing.
// - Bit 4 reads timeout status.
// - Lock key closes configuration space.
module indexed_port_watchdog_timer #(
    parameter CYCLES_PER_SECOND = `CLOCK_HZ
) (
    input  wire        clock,
    input  wire        rst,
    input  wire [15:0] io_addr,
    input  wire [7:0]  io_wdata,
    input  wire        io_wr,
    input  wire        io_rd,
    input  wire        keyboard_activity,
    input  wire        reset_or_irq_select_jumper,
    output reg  [7:0]  io_rdata,
    output reg         io_rdata_valid,
    output reg         wdt_reset_out,
    output reg         wdt_irq_n
);
    reg  [7:0] index_q;
    reg  [7:0] ldev_q;
    reg        enable_q;
    reg  [7:0] unit_reg_q;
    reg  [7:0] reload_q;
    reg  [7:0] count_q;
    reg        kbd_en_q;
    reg        status_q;
    reg  [7:0] count_d;
    reg        status_d;
    reg        restart;
    reg        fire;
    wire       unlocked;
    wire       unit_tick;
    wire       index_wr = io_wr && (io_addr == `IO_INDEX_PORT);
    wire       data_wr  = io_wr && (io_addr == `IO_DATA_PORT);
    wire       data_rd  = io_rd && (io_addr == `IO_DATA_PORT);
    wire       wd_sel   = unlocked && (ldev_q == `LDEV_WATCHDOG);
    // Index is only honoured once the space is open; relies on index-first order.
    wire       cfg_wr   = data_wr && unlocked;
    wire       wd_wr    = data_wr && wd_sel;
    wire       ctrl_wr  = wd_wr && (index_q == `IDX_CTRL_STATUS);

    unlock_detector u_unlock (
        .clock    (clock),
        .rst      (rst),
        .index_wr (index_wr),
        .wdata    (io_wdata),
        .unlocked (unlocked)
    );

    unit_tick_gen #(
        .CYCLES_PER_SECOND (CYCLES_PER_SECOND)
    ) u_tick (
        .clock     (clock),
        .rst       (rst),
        .restart   (restart),
        .minutes   (unit_reg_q[`BIT_UNIT_MINUTES]),
        .unit_tick (unit_tick)
    );

    // ==========================================================
    // Index and configuration registers.
    always @(posedge clock) begin
        if (rst) begin
            index_q    <= `ZERO8;
            ldev_q     <= `ZERO8;
            enable_q   <= 1'b0;
            unit_reg_q <= `ZERO8;
            reload_q   <= `ZERO8;
            kbd_en_q   <= 1'b0;
        end else begin
            if (index_wr && unlocked)
                index_q <= io_wdata;
            if (cfg_wr && index_q == `IDX_LDEV_SELECT)
                ldev_q <= io_wdata;
            if (wd_wr && index_q == `IDX_FUNC_ENABLE)
                enable_q <= (io_wdata == `FUNC_ON);
            if (wd_wr && index_q == `IDX_UNIT_SELECT)
                unit_reg_q <= io_wdata;
            if (wd_wr && index_q == `IDX_TIMEOUT_COUNT)
                reload_q <= io_wdata;
            if (ctrl_wr)
                kbd_en_q <= io_wdata[`BIT_KBD_RESTART];
        end
    end

    // ==========================================================
    // Countdown.
    // A keyboard restart reloads the last written count.
    always @* begin
        restart  = 1'b0;
        fire     = 1'b0;
        count_d  = count_q;
        status_d = status_q;
        if (wd_wr && index_q == `IDX_TIMEOUT_COUNT) begin
            restart  = 1'b1;
            count_d  = io_wdata;
            status_d = 1'b0;
        end else if (kbd_en_q && keyboard_activity) begin
            restart  = 1'b1;
            count_d  = reload_q;
            status_d = 1'b0;
        end else if (enable_q && count_q != `ZERO8 && unit_tick) begin
            count_d = count_q - 8'h01;
            if (count_q == 8'h01)
                fire = 1'b1;
        end
        if (ctrl_wr && io_wdata[`BIT_FORCE_TIMEOUT])
            fire = 1'b1;
        if (fire)
            status_d = 1'b1;
    end

    always @(posedge clock) begin
        if (rst) begin
            count_q  <= `ZERO8;
            status_q <= 1'b0;
        end else begin
            count_q  <= count_d;
            status_q <= status_d;
        end
    end

    // ==========================================================
    // Timeout outputs.
    // The reset is a pulse; the interrupt is held low until a restart.
    always @(posedge clock) begin
        if (rst) begin
            wdt_reset_out <= 1'b0;
            wdt_irq_n     <= 1'b1;
        end else begin
            wdt_reset_out <= fire && reset_or_irq_select_jumper;
            if (fire && !reset_or_irq_select_jumper)
                wdt_irq_n <= 1'b0;
            else if (restart)
                wdt_irq_n <= 1'b1;
        end
    end

    // ==========================================================
    // Data port reads. Bit 5 always reads zero since it clears itself.
    always @(posedge clock) begin
        if (rst) begin
            io_rdata       <= `ZERO8;
            io_rdata_valid <= 1'b0;
        end else begin
            io_rdata_valid <= data_rd;
            io_rdata       <= `ZERO8;
            if (data_rd && unlocked) begin
                if (index_q == `IDX_LDEV_SELECT)
                    io_rdata <= ldev_q;
                else if (wd_sel && index_q == `IDX_FUNC_ENABLE)
                    io_rdata <= {7'h00, enable_q};
                else if (wd_sel && index_q == `IDX_UNIT_SELECT)
                    io_rdata <= unit_reg_q;
                else if (wd_sel && index_q == `IDX_TIMEOUT_COUNT)
                    io_rdata <= count_q;
                else if (wd_sel && index_q == `IDX_CTRL_STATUS)
                    io_rdata <= {1'b0, kbd_en_q, 1'b0, status_q, 4'h0};
            end
        end
    end
endmodule // indexed_port_watchdog_timer

// File: design/unit_tick_gen.v
// Time base: a one-cycle pulse once per second or once per minute.
// Assumes one clock at CLOCK_HZ and a synchronous active-high reset.
`timescale 1ns/100ps
`include "wdt_defines.vh"
module unit_tick_gen #(
    parameter CYCLES_PER_SECOND = `CLOCK_HZ
) (
    input  wire clock,
    input  wire rst,
    input  wire restart,
    input  wire minutes,
    output reg  unit_tick
);
    reg [31:0] sec_cnt_q;
    reg [5:0]  min_cnt_q;
    wire       sec_tick = (sec_cnt_q == CYCLES_PER_SECOND - 1);
    // ==========================================================
    // Prescaler.
    // Restart realigns the prescaler so a fresh count gets full units.
    always @(posedge clock) begin
        if (rst || restart) begin
            sec_cnt_q <= 32'h0000_0000;
            min_cnt_q <= 6'h00;
            unit_tick <= 1'b0;
        end else begin
            sec_cnt_q <= sec_tick ? 32'h0000_0000 : sec_cnt_q + 32'h0000_0001;
            if (sec_tick)
                min_cnt_q <= (min_cnt_q == `SECONDS_PER_MINUTE - 1) ? 6'h00 : min_cnt_q + 6'h01;
            unit_tick <= sec_tick && (!minutes || min_cnt_q == `SECONDS_PER_MINUTE - 1);
        end
    end
endmodule // unit_tick_gen

// File: design/unlock_detector.v
// Watches index-port writes for the double unlock key and the lock key.
// Assumes one write strobe per cycle at most, synchronous to the clock.
`timescale 1ns/100ps
`include "wdt_defines.vh"
module unlock_detector (
    input  wire       clock,
    input  wire       rst,
    input  wire       index_wr,
    input  wire [7:0] wdata,
    output reg        unlocked
);
    reg first_key_q;
    // ==========================================================
    // Key sequence.
    // Any other index write between the two keys spoils the sequence.
    always @(posedge clock) begin
        if (rst) begin
            first_key_q <= 1'b0;
            unlocked    <= 1'b0;
        end else if (index_wr) begin
            if (wdata == `KEY_LOCK) begin
                unlocked    <= 1'b0;
                first_key_q <= 1'b0;
            end else if (wdata == `KEY_UNLOCK) begin
                if (first_key_q)
                    unlocked <= 1'b1;
                first_key_q <= ~first_key_q;
            end else begin
                first_key_q <= 1'b0;
            end
        end
    end
endmodule // unlock_detector

// File: design/wdt_defines.vh
// Constants for the indexed-port watchdog: port addresses, keys, register
// indices, field positions and time base.
// Assumes a 100 MHz clock and an 8-bit I/O data path.
`ifndef WDT_DEFINES_VH
`define WDT_DEFINES_VH
`define IO_INDEX_PORT      16'h002e
`define IO_DATA_PORT       16'h002f
`define KEY_UNLOCK         8'h87
`define KEY_LOCK           8'haa
`define IDX_LDEV_SELECT    8'h07
`define IDX_FUNC_ENABLE    8'h30
`define IDX_UNIT_SELECT    8'hf5
`define IDX_TIMEOUT_COUNT  8'hf6
`define IDX_CTRL_STATUS    8'hf7
`define LDEV_WATCHDOG      8'h08
`define FUNC_ON            8'h01
`define BIT_UNIT_MINUTES   3
`define BIT_KBD_RESTART    6
`define BIT_FORCE_TIMEOUT  5
`define BIT_TIMEOUT_STATUS 4
`define CLOCK_HZ           100000000
`define SECONDS_PER_MINUTE 60
`define ZERO8              8'h00
`endif

// File: test/io_host.sv
// Host model: issues I/O writes and reads on the index/data ports.
// Assumes calls start just after a rising clock edge.
`timescale 1ns/100ps
module io_host (
    input  wire        clock,
    input  wire [7:0]  io_rdata,
    input  wire        io_rdata_valid,
    output reg  [15:0] io_addr,
    output reg  [7:0]  io_wdata,
    output reg         io_wr,
    output reg         io_rd
);
    // ==========================================
    // Bus tasks
    // An idle bus shows inverted values so stale data is never taken as live.
    initial begin
        io_addr = 16'h0000;
        io_wdata = 8'h00;
        io_wr = 1'b0;
        io_rd = 1'b0;
    end
    task wr(input [15:0] a, input [7:0] d);
        begin
            io_addr <= a;
            io_wdata <= d;
            io_wr <= 1'b1;
            @(posedge clock);
            io_wr <= 1'b0;
            io_addr <= ~a;
            io_wdata <= ~d;
            @(posedge clock);
        end
    endtask
    task reg_wr(input [7:0] i, input [7:0] d);
        begin
            wr(16'h002e, i);
            wr(16'h002f, d);
        end
    endtask
    task rd(input [7:0] i, output [7:0] d, output v);
        begin
            wr(16'h002e, i);
            io_addr <= 16'h002f;
            io_rd <= 1'b1;
            @(posedge clock);
            io_rd <= 1'b0;
            io_addr <= 16'hffd0;
            #1;
            d = io_rdata;
            v = io_rdata_valid;
            @(posedge clock);
        end
    endtask
    task open_wdt;
        begin
            wr(16'h002e, 8'h87);
            wr(16'h002e, 8'h87);
            reg_wr(8'h07, 8'h08);
        end
    endtask
endmodule // io_host

// File: test/tb_top.sv
// Self-checking bench for the watchdog with a shortened time base.
// Assumes the host model drives all I/O strobes.
`timescale 1ns/100ps
module tb_top;
    localparam CPS = 10;
    reg         clock;
    reg         rst;
    reg         kbd;
    reg         jmp;
    wire [15:0] io_addr;
    wire [7:0]  io_wdata;
    wire        io_wr;
    wire        io_rd;
    wire [7:0]  io_rdata;
    wire        io_rdata_valid;
    wire        wdt_reset_out;
    wire        wdt_irq_n;
    integer     n_errors;
    integer     cmp_count;
    integer     cyc;
    integer     pulses;
    integer     p;
    integer     t;
    integer     i;
    reg [31:0]  seed;
    reg [7:0]   d;
    reg         v;
    reg [7:0]   cnt;
    indexed_port_watchdog_timer #(.CYCLES_PER_SECOND(CPS)) indexed_port_watchdog_timer_inst (.clock(clock),
        .rst(rst), .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .keyboard_activity(kbd),
        .reset_or_irq_select_jumper(jmp), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
        .wdt_reset_out(wdt_reset_out), .wdt_irq_n(wdt_irq_n));
    io_host io_host_inst (.clock(clock), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd));
    // ==========================================
    // Helpers
    function [31:0] lfsr(input [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function [7:0] win(input integer t, input integer u);
        win = (t >= u - 1 && t <= u + 4) ? 8'h01 : 8'h00;
    endfunction
    task chk(input [63:0] nm, input [7:0] got, input [7:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("unexpected %0s exp %h got %h", nm, exp, got);
            end
        end
    endtask
    task wait_tout;
        begin
            t = 0;
            while (wdt_irq_n !== 1'b0 && pulses == p && t < 1000) begin
                @(posedge clock);
                #1;
                t = t + 1;
            end
        end
    endtask
    task give_verdict;
        begin
            $display("errors %0d compares %0d", n_errors, cmp_count);
            if (n_errors == 0 && cmp_count > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (wdt_reset_out === 1'b1) pulses <= pulses + 1;
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            give_verdict;
        end
    end
    // ==========================================
    // Scenarios
    initial begin
        n_errors = 0;
        cmp_count = 0;
        cyc = 0;
        pulses = 0;
        p = 0;
        seed = 32'h68c7dc07;
        rst = 1'b1;
        kbd = 1'b0;
        jmp = 1'b0;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        chk("irq", {7'h00, wdt_irq_n}, 8'h01);
        // A broken key pair must leave the space locked.
        io_host_inst.wr(16'h002e, 8'h87);
        io_host_inst.wr(16'h002e, 8'h00);
        io_host_inst.wr(16'h002e, 8'h87);
        io_host_inst.reg_wr(8'hf6, 8'h05);
        io_host_inst.rd(8'hf6, d, v);
        chk("lockrd", d, 8'h00);
        io_host_inst.open_wdt;
        io_host_inst.rd(8'hf6, d, v);
        chk("count", d, 8'h00);
        chk("valid", {7'h00, v}, 8'h01);
        io_host_inst.rd(8'h55, d, v);
        chk("unmap", d, 8'h00);
        io_host_inst.rd(8'h07, d, v);
        chk("ldev", d, 8'h08);
        io_host_inst.reg_wr(8'hf6, 8'h01);
        repeat (40) @(posedge clock);
        chk("dis", {7'h00, wdt_irq_n}, 8'h01);
        io_host_inst.reg_wr(8'h30, 8'h01);
        for (i = 0; i < 3; i = i + 1) begin
            seed = lfsr(seed);
            cnt = 8'h01 + {6'h00, seed[1:0]};
            io_host_inst.reg_wr(8'hf6, cnt);
            wait_tout;
            chk("tout", win(t, cnt * CPS), 8'h01);
            io_host_inst.rd(8'hf7, d, v);
            chk("stat", {7'h00, d[4]}, 8'h01);
            kbd <= 1'b1;
            @(posedge clock);
            kbd <= 1'b0;
            repeat (20) @(posedge clock);
            chk("hold", {7'h00, wdt_irq_n}, 8'h00);
        end
        io_host_inst.reg_wr(8'hf7, 8'h40);
        kbd <= 1'b1;
        @(posedge clock);
        kbd <= 1'b0;
        repeat (3) @(posedge clock);
        chk("kbd", {7'h00, wdt_irq_n}, 8'h01);
        io_host_inst.reg_wr(8'hf5, 8'h08);
        io_host_inst.rd(8'hf5, d, v);
        chk("unit", d, 8'h08);
        io_host_inst.reg_wr(8'hf6, 8'h01);
        wait_tout;
        chk("minute", win(t, 60 * CPS), 8'h01);
        io_host_inst.reg_wr(8'hf6, 8'h00);
        repeat (3) @(posedge clock);
        jmp <= 1'b1;
        p = pulses;
        io_host_inst.reg_wr(8'hf7, 8'h60);
        repeat (3) @(posedge clock);
        chk("force", pulses - p, 8'h01);
        io_host_inst.rd(8'hf7, d, v);
        chk("selfclr", {6'h00, d[5:4]}, 8'h01);
        io_host_inst.reg_wr(8'hf5, 8'h00);
        p = pulses;
        io_host_inst.reg_wr(8'hf6, 8'h01);
        wait_tout;
        chk("rstout", pulses - p, 8'h01);
        io_host_inst.wr(16'h002e, 8'haa);
        io_host_inst.reg_wr(8'hf6, 8'h05);
        io_host_inst.open_wdt;
        io_host_inst.rd(8'hf6, d, v);
        chk("relock", d, 8'h00);
        give_verdict;
    end
endmodule // tb_top

// File: test/wdt_props.sv
// Assertions on the watchdog's I/O ports.
// Assumes one clock with a synchronous active-high reset.
`timescale 1ns/100ps
module wdt_props (
    input wire        clock,
    input wire        rst,
    input wire [15:0] io_addr,
    input wire        io_wr,
    input wire        io_rd,
    input wire        keyboard_activity,
    input wire        reset_or_irq_select_jumper,
    input wire        io_rdata_valid,
    input wire        wdt_reset_out,
    input wire        wdt_irq_n
);
    // ==========================================
    // Properties
    reg rst_q;
    always @(posedge clock) rst_q <= rst;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence data_rd;
        io_rd && io_addr == 16'h002f;
    endsequence
    rd_answer_a: assert property (data_rd |=> io_rdata_valid) else $error("read not answered");
    rd_quiet_a: assert property (!(io_rd && io_addr == 16'h002f) |=> !io_rdata_valid)
        else $error("stray read valid");
    pulse_once_a: assert property (wdt_reset_out |=> !wdt_reset_out) else $error("reset pulse too long");
    irq_jumper_a: assert property (reset_or_irq_select_jumper |-> wdt_irq_n) else $error("irq in reset mode");
    rst_jumper_a: assert property (!reset_or_irq_select_jumper |-> !wdt_reset_out)
        else $error("reset in irq mode");
    irq_fall_a: assert property ($fell(wdt_irq_n) |-> !$past(reset_or_irq_select_jumper))
        else $error("irq fell in reset mode");
    irq_rise_a: assert property ($rose(wdt_irq_n) |-> $past(io_wr) || $past(io_wr, 2) ||
        $past(keyboard_activity) || $past(keyboard_activity, 2)) else $error("irq released without restart");
    reset_rel_a: assert property (rst_q |-> wdt_irq_n && !wdt_reset_out && !io_rdata_valid)
        else $error("outputs not idle after reset");
endmodule // wdt_props
bind indexed_port_watchdog_timer wdt_props wdt_props_inst (.*);
